// ==== rtl/sep_pkg.sv ====
// Shared constants and types for the serial memory command port
package sep_pkg;
  // System clock period
  localparam int CLK_NS = 5;
  // Least deselect time before status may be shown
  localparam int DESEL_MIN_NS = 250;
  localparam int DESEL_CYC = (DESEL_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Self-timed cycle lengths, erase, erase-all and write alike
  localparam int PROG_MS = 6;
  localparam int FILL_MS = 15;
  localparam int PROG_CYC = PROG_MS * 1000000 / CLK_NS;
  localparam int FILL_CYC = FILL_MS * 1000000 / CLK_NS;
  // Width of the self-timed cycle counter
  localparam int TMR_W = 22;
  // Default organisation: 16-bit words, 6-bit address
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int FIFO_DEPTH = 16;
  // Opcodes following the start bit
  localparam logic [1:0] OPC_EXT = 2'h0;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  // Sub-codes in the two address MSBs under OPC_EXT
  localparam logic [1:0] SUB_DISABLE = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_WIPE = 2'h2;
  localparam logic [1:0] SUB_ENABLE = 2'h3;
  // Reset value of the program-enable latch
  localparam logic PROG_EN_RST = 1'b0;
  // Command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADR, ST_DAT, ST_RD, ST_DONE
  } sep_state_e;
  // Programming operations
  typedef enum logic [2:0] {
    PG_NONE, PG_ERASE, PG_WIPE, PG_WRITE, PG_FILL
  } sep_prog_e;
endpackage : sep_pkg

// ==== rtl/sep_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module sep_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // Plain two-stage capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sep_sync
`default_nettype wire

// ==== rtl/sep_fifo.sv ====
// Small flop FIFO with valid/ready on both sides and a flush
`timescale 1ns/100ps
`default_nettype none
module sep_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  // Pointer arithmetic relies on power-of-two depth
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Honest flags from the occupancy count
  assign in_ready = (cnt_q != DEPTH[PW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // Pointers and count; flush empties at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + PW'(push);
      rd_q <= rd_q + PW'(pop);
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : sep_fifo
`default_nettype wire

// ==== rtl/sep_cmd_port.sv ====
// Command front end of a small serial nonvolatile memory
// Notes on behaviour
// R1 - No start accepted during programming cycle
// R2 - Deselect holds command logic in reset
// R3 - Sample input, change output on clock rise
// R4 - Paused clock keeps shift position
// R5 - Clock ignored deselected or before start
// R6 - Start is first rise with select, input high
// R7 - Execute only after all bits arrive
// R8 - After last bit, ignore until new start
// R9 - Opcodes and sub-codes select the instruction
// R10 - Address and data lengths follow organisation
// R11 - Output floats except data or status
// R12 - Status after deselect time: low busy
// R13 - No status if held deselected; later high
// R14 - Dummy zero precedes read data
// R15 - No programming while supply is low
// R16 - Powers up program-disabled
// R17 - Enable holds until disable or power loss
// R18 - Reads work in either enable state
// R19 - Deselect edge starts word erase
// R20 - Erase-all starts on deselect edge too
// R21 - Self-timed cycle needs no serial clock
// R22 - Write: data, then deselect starts cycle
// R23 - Held select keeps reading next words
// R24 - Write-all erases then writes everything
// R25 - Disabled programming commands change nothing
// R26 - Cycle length is a counted parameter
`timescale 1ns/100ps
`default_nettype none
module sep_cmd_port #(
  parameter int DATA_W = sep_pkg::DATA_W,
  parameter int ADDR_W = sep_pkg::ADDR_W,
  parameter int PROG_CYC = sep_pkg::PROG_CYC,
  parameter int FILL_CYC = sep_pkg::FILL_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic DEV_SEL,
  input wire logic SER_CLK,
  input wire logic SER_IN,
  input wire logic SUPPLY_GOOD,
  output logic SER_OUT_O,
  output logic SER_OUT_OE
);
  localparam int TW = sep_pkg::TMR_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BW = $clog2(DATA_W + 1);
  localparam int DW = $clog2(sep_pkg::DESEL_CYC + 1);
  // Only the two documented organisations are served
  if (!((DATA_W == 16 && ADDR_W == 6) || (DATA_W == 8 && ADDR_W == 7)))
  begin : g_bad_org
    $error("unsupported organisation");
  end
  // Busy must stand at least two cycles for the start checks
  if (PROG_CYC < 2 || FILL_CYC < 2 || PROG_CYC >= (1 << TW) ||
      FILL_CYC >= (1 << TW)) begin : g_bad_cyc
    $error("cycle count out of range");
  end

  // Synchronised pins: select, clock, data, supply
  logic cs_s, sk_s, din_s, pwr_s;
  logic cs_prev_q, sk_prev_q;
  sep_sync #(.W(4)) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .d({DEV_SEL, SER_CLK, SER_IN, SUPPLY_GOOD}),
    .q({cs_s, sk_s, din_s, pwr_s})
  );

  // Edge history from the second stage only
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      cs_prev_q <= 1'b0;
      sk_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      sk_prev_q <= sk_s;
    end
  end
  wire sk_rise = cs_s & sk_s & ~sk_prev_q; // R3 R5
  wire cs_fall = ~cs_s & cs_prev_q;
  wire cs_rise = cs_s & ~cs_prev_q;

  // Sequencer and shift registers
  sep_pkg::sep_state_e state_q, state_d;
  logic [BW-1:0] cnt_q; // Bits taken in the current phase
  logic [1:0] opc_q; // Opcode being shifted in
  logic [ADDR_W-1:0] addr_q; // Address being shifted in
  logic [DATA_W-1:0] sh_q; // Write data being shifted in
  logic prog_en_q; // Program-enabled state
  logic busy_q; // Self-timed cycle running
  sep_pkg::sep_prog_e pend_q; // Armed op, waits for deselect edge

  // Start bit: only from idle, never while programming
  wire start_det = sk_rise & din_s & (state_q == sep_pkg::ST_IDLE) &
                   ~busy_q; // R6 R1
  wire opc_last = (state_q == sep_pkg::ST_OPC) & sk_rise &
                  (cnt_q == BW'(1));
  wire adr_last = (state_q == sep_pkg::ST_ADR) & sk_rise &
                  (cnt_q == BW'(ADDR_W - 1)); // R10
  wire dat_last = (state_q == sep_pkg::ST_DAT) & sk_rise &
                  (cnt_q == BW'(DATA_W - 1)); // R10
  wire [ADDR_W-1:0] addr_full = {addr_q[ADDR_W-2:0], din_s};
  wire [1:0] sub = addr_full[ADDR_W-1 -: 2]; // R9
  wire is_ext = (opc_q == sep_pkg::OPC_EXT);
  wire is_read = (opc_q == sep_pkg::OPC_READ); // R9
  wire is_fill = is_ext & (sub == sep_pkg::SUB_FILL);
  // In the data phase the live shift is stale; use the held address
  wire fill_held = is_ext &
                   (addr_q[ADDR_W-1 -: 2] == sep_pkg::SUB_FILL); // R24
  wire takes_data = (opc_q == sep_pkg::OPC_WRITE) | is_fill; // R22
  wire do_erase = (opc_q == sep_pkg::OPC_ERASE) & adr_last;
  wire do_wipe = is_ext & (sub == sep_pkg::SUB_WIPE) & adr_last;
  wire do_en = is_ext & (sub == sep_pkg::SUB_ENABLE) & adr_last;
  wire do_dis = is_ext & (sub == sep_pkg::SUB_DISABLE) & adr_last;
  wire dummy_ev = adr_last & is_read; // R14

  // Next state; paused clock simply means no rise
  always_comb begin
    state_d = state_q; // R4
    if (!cs_s) begin
      state_d = sep_pkg::ST_IDLE; // R2
    end else if (start_det) begin
      state_d = sep_pkg::ST_OPC;
    end else if (opc_last) begin
      state_d = sep_pkg::ST_ADR;
    end else if (adr_last) begin
      // Read streams, writes take data, the rest are complete
      if (is_read) begin
        state_d = sep_pkg::ST_RD; // R18
      end else if (takes_data) begin
        state_d = sep_pkg::ST_DAT;
      end else begin
        state_d = sep_pkg::ST_DONE; // R8
      end
    end else if (dat_last) begin
      state_d = sep_pkg::ST_DONE; // R8
    end
  end

  // State and phase bit count
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_q <= sep_pkg::ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      if (!cs_s || start_det || opc_last || adr_last) begin
        cnt_q <= '0; // R2
      end else if (sk_rise) begin
        cnt_q <= cnt_q + BW'(1);
      end
    end
  end

  // Field capture, each in its own phase
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      opc_q <= '0;
      addr_q <= '0;
      sh_q <= '0;
    end else if (sk_rise) begin
      if (state_q == sep_pkg::ST_OPC) begin
        opc_q <= {opc_q[0], din_s}; // R3
      end
      if (state_q == sep_pkg::ST_ADR) begin
        addr_q <= addr_full;
      end
      if (state_q == sep_pkg::ST_DAT) begin
        sh_q <= {sh_q[DATA_W-2:0], din_s};
      end
    end
  end

  // Enable latch; supply loss counts as power removal
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      prog_en_q <= sep_pkg::PROG_EN_RST; // R16
    end else if (!pwr_s || do_dis) begin
      prog_en_q <= 1'b0; // R17 R15
    end else if (do_en) begin
      prog_en_q <= 1'b1; // R17
    end
  end

  // Arm an op only when all bits are in and enabled
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend_q <= sep_pkg::PG_NONE;
    end else if (!cs_s || start_det) begin
      pend_q <= sep_pkg::PG_NONE; // R7
    end else if (prog_en_q && do_erase) begin
      pend_q <= sep_pkg::PG_ERASE; // R25
    end else if (prog_en_q && do_wipe) begin
      pend_q <= sep_pkg::PG_WIPE; // R25
    end else if (prog_en_q && dat_last) begin
      pend_q <= fill_held ? sep_pkg::PG_FILL : sep_pkg::PG_WRITE; // R24
    end
  end

  // Self-timed engine, runs on the system clock alone
  logic [TW-1:0] tmr_q; // Cycles left
  sep_pkg::sep_prog_e run_q; // Op being programmed
  logic [ADDR_W-1:0] run_addr_q;
  logic [DATA_W-1:0] run_data_q;
  wire prog_start = cs_fall & (pend_q != sep_pkg::PG_NONE) & prog_en_q &
                    pwr_s & ~busy_q; // R19 R20 R22 R15 R25
  wire prog_end = busy_q & (tmr_q == '0); // R26
  wire [TW-1:0] tmr_load = (pend_q == sep_pkg::PG_FILL) ?
                           TW'(FILL_CYC - 1) : TW'(PROG_CYC - 1);

  // Count down; no serial clock involved
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      busy_q <= 1'b0;
      tmr_q <= '0;
      run_q <= sep_pkg::PG_NONE;
      run_addr_q <= '0;
      run_data_q <= '0;
    end else if (prog_start) begin
      busy_q <= 1'b1;
      tmr_q <= tmr_load; // R26
      run_q <= pend_q;
      run_addr_q <= addr_q;
      run_data_q <= sh_q;
    end else if (prog_end) begin
      busy_q <= 1'b0; // R21
    end else if (busy_q) begin
      tmr_q <= tmr_q - TW'(1); // R21
    end
  end

  // Array; erase forms write ones, whole-array forms hit all
  logic [DATA_W-1:0] mem_q [DEPTH];
  wire commit = prog_end & pwr_s; // R15
  wire all_op = (run_q == sep_pkg::PG_WIPE) | (run_q == sep_pkg::PG_FILL);
  wire ones_op = (run_q == sep_pkg::PG_WIPE) |
                 (run_q == sep_pkg::PG_ERASE); // R19 R20
  wire [DATA_W-1:0] wr_val = ones_op ? '1 : run_data_q; // R24
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '1;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (commit && (all_op || run_addr_q == ADDR_W'(i))) begin
          mem_q[i] <= wr_val;
        end
      end
    end
  end

  // Read prefetch into the FIFO; stalls when it fills
  logic [ADDR_W-1:0] pf_addr_q;
  logic pf_ready, rd_valid;
  logic [DATA_W-1:0] rd_word;
  wire in_rd = (state_q == sep_pkg::ST_RD);
  logic [BW-1:0] out_left_q; // Bits still to send of word
  logic [DATA_W-1:0] out_sh_q;
  wire rd_rise = in_rd & sk_rise;
  wire need_word = rd_rise & (out_left_q == '0);
  wire pop = need_word & rd_valid;
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      pf_addr_q <= '0;
    end else if (adr_last) begin
      pf_addr_q <= addr_full;
    end else if (in_rd && pf_ready) begin
      pf_addr_q <= pf_addr_q + ADDR_W'(1); // R23
    end
  end
  // Flushed whenever no read runs, so stale words never leak
  sep_fifo #(.W(DATA_W), .DEPTH(sep_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .clr(~in_rd),
    .in_valid(in_rd),
    .in_ready(pf_ready),
    .in_data(mem_q[pf_addr_q]),
    .out_valid(rd_valid),
    .out_ready(pop),
    .out_data(rd_word)
  );

  // Output shifter; a late word holds the line rather than slip
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_left_q <= '0;
      out_sh_q <= '0;
    end else if (!in_rd) begin
      out_left_q <= '0;
    end else if (pop) begin
      out_sh_q <= {rd_word[DATA_W-2:0], 1'b0};
      out_left_q <= BW'(DATA_W - 1);
    end else if (rd_rise && out_left_q != '0) begin
      out_sh_q <= {out_sh_q[DATA_W-2:0], 1'b0};
      out_left_q <= out_left_q - BW'(1);
    end
  end

  // Status bookkeeping: deselect timer and pending report
  logic [DW-1:0] low_cnt_q;
  logic stat_pend_q, stat_drive_q;
  wire desel_ok = (low_cnt_q == DW'(sep_pkg::DESEL_CYC)); // R12
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      low_cnt_q <= '0;
    end else if (cs_s) begin
      low_cnt_q <= '0;
    end else if (!desel_ok) begin
      low_cnt_q <= low_cnt_q + DW'(1);
    end
  end
  // Report stays owed until shown once with the cycle over
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      stat_pend_q <= 1'b0;
      stat_drive_q <= 1'b0;
    end else begin
      if (prog_start) begin
        stat_pend_q <= 1'b1; // Set wins over clear
      end else if (cs_fall && stat_drive_q && !busy_q) begin
        stat_pend_q <= 1'b0; // R13
      end
      if (!cs_s || start_det) begin
        stat_drive_q <= 1'b0; // R11
      end else if (cs_rise && stat_pend_q && desel_ok) begin
        stat_drive_q <= 1'b1; // R12 R13
      end
    end
  end

  // Pin drive; data and dummy bits change on serial clock rises, status and float on select or busy
  logic do_d, oe_d, do_q, oe_q;
  always_comb begin
    do_d = 1'b1;
    oe_d = 1'b0;
    if (!cs_s) begin
      oe_d = 1'b0; // R11
    end else if (dummy_ev) begin
      do_d = 1'b0; // R14
      oe_d = 1'b1;
    end else if (in_rd) begin
      oe_d = 1'b1;
      do_d = do_q; // Hold between clock rises
      if (pop) begin
        do_d = rd_word[DATA_W-1]; // R3
      end else if (rd_rise && out_left_q != '0) begin
        do_d = out_sh_q[DATA_W-1]; // R23
      end
    end else if (stat_drive_q) begin
      do_d = ~busy_q; // R12
      oe_d = 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      do_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      do_q <= do_d;
      oe_q <= oe_d;
    end
  end
  assign SER_OUT_O = do_q;
  assign SER_OUT_OE = oe_q;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  float_desel_a: assert property (!cs_s |=> !oe_q) // R11
    else $error("output driven while deselected");
  desel_reset_a: assert property (!cs_s |=> state_q == sep_pkg::ST_IDLE &&
    pend_q == sep_pkg::PG_NONE) // R2
    else $error("control not reset while deselected");
  idle_hold_a: assert property (state_q == sep_pkg::ST_IDLE &&
    !start_det |=> state_q == sep_pkg::ST_IDLE) // R5 R6
    else $error("left idle without start");
  dummy_zero_a: assert property (dummy_ev |=> oe_q && !do_q) // R14
    else $error("dummy zero missing");
  en_gate_a: assert property ($rose(busy_q) |-> $past(prog_en_q) &&
    $past(pwr_s) && $past(cs_fall)) // R25 R15 R19
    else $error("cycle started without cause");
  busy_low_a: assert property (stat_drive_q && busy_q ##1 stat_drive_q
    |-> oe_q && !do_q) // R12
    else $error("busy status not low");
  timed_end_a: assert property ($fell(busy_q) |-> $past(tmr_q) == '0) // R26
    else $error("cycle ended early");
  full_len_a: assert property ($rose(busy_q) |-> tmr_q ==
    TW'(PROG_CYC - 1) || tmr_q == TW'(FILL_CYC - 1)) // R26
    else $error("cycle length wrong");
  fill_sides_a: assert property (prog_start |-> ##1 busy_q ##1 busy_q) // R21
    else $error("cycle did not hold");
  cov_read_c: cover property (dummy_ev ##[1:200] pop);
  cov_write_c: cover property (prog_start && pend_q == sep_pkg::PG_WRITE);
  cov_status_c: cover property (stat_drive_q && busy_q ##1 !busy_q);
  cov_enable_c: cover property (do_en);
endmodule : sep_cmd_port
`default_nettype wire

// ==== testbench/sep_master.sv ====
// Serial bus master model facing the command port
`timescale 1ns/100ps
`default_nettype none
module sep_master (
  input wire logic clk,
  output var logic dev_sel,
  output var logic ser_clk,
  output var logic ser_in,
  input wire logic ser_out,
  output var logic [63:0] rx
);
  // Link clock half period, 48 ns per bit
  localparam int HALF = 24;
  // Pins idle, clock resting low outside frames
  initial begin
    dev_sel = 1'b0;
    ser_clk = 1'b0;
    ser_in = 1'b0;
    rx = 64'h0;
  end
  // Clock n bits MSB first, output sampled just before each rise
  task automatic send(input logic [63:0] bits, input int n, input int pz);
    // Start just after a system clock rise so no sample races an edge
    @(posedge clk);
    #1;
    dev_sel = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      ser_in = bits[i];
      #HALF;
      rx = {rx[62:0], ser_out};
      ser_clk = 1'b1;
      #HALF;
      // Optional long stop with the clock held high
      if (i == pz) begin
        #(HALF * 20);
      end
      ser_clk = 1'b0;
    end
    #HALF;
    rx = {rx[62:0], ser_out};
  endtask : send
  // Hold select at a level for some system cycles
  task automatic hold(input logic s, input int cyc);
    // Same alignment; checks after a hold then see settled outputs
    @(posedge clk);
    #1;
    dev_sel = s;
    repeat (cyc) begin
      #5;
      // Data line toggles while released, never stale
      if (!s) begin
        ser_in = ~ser_in;
      end
    end
  endtask : hold
endmodule : sep_master
`default_nettype wire

// ==== testbench/sep_cmd_port_bench.sv ====
// Self-checking bench for the serial memory command port
`timescale 1ns/100ps
`default_nettype none
module sep_cmd_port_bench;
  // Short self-timed cycles keep the run brief
  localparam int PC = 200;
  localparam int WC = 300;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic supply_good = 1'b1;
  logic o;
  logic oe;
  logic [63:0] rx;
  wire dev_sel;
  wire ser_clk;
  wire ser_in;
  // Output pin floats unless the device drives it
  wire ser_out = oe ? o : 1'bz;
  int fail_count = 0;
  int checked = 0;
  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;
  sep_cmd_port #(.PROG_CYC(PC), .FILL_CYC(WC)) u_dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .DEV_SEL(dev_sel),
    .SER_CLK(ser_clk), .SER_IN(ser_in), .SUPPLY_GOOD(supply_good),
    .SER_OUT_O(o), .SER_OUT_OE(oe)
  );
  sep_master u_m (
    .clk(clk_sys),
    .dev_sel(dev_sel), .ser_clk(ser_clk), .ser_in(ser_in),
    .ser_out(ser_out), .rx(rx)
  );
  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Counts, verdict and end of run
  task automatic give_verdict();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // One frame then a deselect long enough for status
  task automatic op(input logic [63:0] b, input int n);
    u_m.send(b, n, -1);
    u_m.hold(1'b0, 60);
  endtask : op
  // Read nw words; don't-care input bits are ones
  task automatic rd(input logic [5:0] a, input int nw, input int lead,
      input int pz);
    int n;
    n = 9 + 16 * nw;
    u_m.send((64'h6 << (n - 3)) | ({58'h0, a} << (n - 9))
      | ((64'h1 << (n - 9)) - 64'h1), n + lead, pz);
    u_m.hold(1'b0, 60);
    check(oe, 1'b0);
  endtask : rd
  // Raise select and follow the busy then ready status
  task automatic stat(input int cyc);
    int k;
    u_m.hold(1'b1, 10);
    check({oe, o}, 2'b10);
    u_m.hold(1'b1, cyc - 80);
    check({oe, o}, 2'b10);
    k = 0;
    while (o !== 1'b1 && k < 40) begin
      u_m.hold(1'b1, 1);
      k++;
    end
    check({oe, o}, 2'b11);
    u_m.hold(1'b0, 60);
  endtask : stat
  // Raise select after a command that owes no status
  task automatic no_stat(input int low);
    u_m.hold(1'b0, low);
    u_m.hold(1'b1, 10);
    check(oe, 1'b0);
    u_m.hold(1'b0, 60);
  endtask : no_stat
  // Fresh part: idle clocks, pause, dummy zero, erased array
  task automatic t_first_read();
    check(oe, 1'b0);
    rd(6'h05, 1, 4, 12);
    check(rx[16:0], 17'h0FFFF);
  endtask : t_first_read
  // Write refused before enable
  task automatic t_disabled();
    op({39'h0, 3'b101, 6'h05, 16'h1234}, 25);
    no_stat(60);
    rd(6'h05, 1, 0, -1);
    check(rx[15:0], 16'hFFFF);
  endtask : t_disabled
  // Enable with extra clocks, write, sequential read
  task automatic t_write();
    op({52'h0, 9'h130, 3'b111}, 12);
    u_m.send({39'h0, 3'b101, 6'h05, 16'hA5C3}, 25, 8);
    u_m.hold(1'b0, 60);
    stat(PC);
    rd(6'h05, 2, 0, -1);
    check(rx[32:0], {1'b0, 16'hA5C3, 16'hFFFF});
  endtask : t_write
  // Erase with select held low for the whole cycle
  task automatic t_erase_low();
    u_m.send({55'h0, 3'b111, 6'h05}, 9, -1);
    u_m.hold(1'b0, PC + 100);
    u_m.hold(1'b1, 10);
    check({oe, o}, 2'b11);
    u_m.hold(1'b0, 60);
    rd(6'h05, 1, 0, -1);
    check(rx[15:0], 16'hFFFF);
  endtask : t_erase_low
  // Write cut short by an early deselect
  task automatic t_partial();
    u_m.send({39'h0, 3'b101, 6'h06, 16'h0000} >> 10, 15, -1);
    no_stat(PC + 100);
    rd(6'h06, 1, 0, -1);
    check(rx[15:0], 16'hFFFF);
  endtask : t_partial
  // Write-all, wrap of sequential read, then erase-all
  task automatic t_all();
    op({39'h0, 9'h110, 16'h0F0F}, 25);
    stat(WC);
    rd(6'h3F, 2, 0, -1);
    check(rx[32:0], {1'b0, 16'h0F0F, 16'h0F0F});
    op({55'h0, 9'h120}, 9);
    stat(PC);
    rd(6'h00, 1, 0, -1);
    check(rx[15:0], 16'hFFFF);
  endtask : t_all
  // Enable persists, then disable blocks an erase
  task automatic t_disable();
    op({39'h0, 3'b101, 6'h07, 16'h00FF}, 25);
    stat(PC);
    op({55'h0, 9'h100}, 9);
    u_m.send({55'h0, 3'b111, 6'h07}, 9, -1);
    no_stat(60);
    rd(6'h07, 1, 0, -1);
    check(rx[15:0], 16'h00FF);
  endtask : t_disable
  // Low supply blocks a write; reads still work
  task automatic t_supply();
    op({55'h0, 9'h130}, 9);
    @(posedge clk_sys);
    #1 supply_good = 1'b0;
    op({39'h0, 3'b101, 6'h08, 16'h0000}, 25);
    no_stat(PC + 100);
    rd(6'h08, 1, 0, -1);
    check(rx[15:0], 16'hFFFF);
    @(posedge clk_sys);
    #1 supply_good = 1'b1;
  endtask : t_supply
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    t_first_read();
    t_disabled();
    t_write();
    t_erase_low();
    t_partial();
    t_all();
    t_disable();
    t_supply();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    fail_count++;
    give_verdict();
  end
endmodule : sep_cmd_port_bench
`default_nettype wire
